// File: logic/cmc_clock_mode_control.sv
// Notes on behaviour
// - cpu fast clock is oscillator over 2^div
// - slow oscillator drives 14-bit time base divider
// - time base taps feed lcd, pump, watchdog
// - writing zero to bit 2 clears time base
// - bit 2 always reads back as one
// - bit 3 enables time base, default on
// - bit 7 selects fast or slow cpu clock
// - clearing bit 7 in normal enters slow
// - key 0x5A to sleep register stops cpu
// - after reset start normal on fast clock
// - normal runs fast oscillator, slow per enable
// - slow mode stops fast, keeps time base
// - standby keeps slow clock, four wake sources
// - halt stops everything, key or external wakes
// - peripherals run by their own enables
// - sleep picks standby if time base enabled
// - wake returns to mode chosen by bit 7
// - fast oscillator settles 512 cycles first
`timescale 1ns/1ps
module cmc_clock_mode_control (
	// clock and reset
	input  wire logic                            CLK,
	input  wire logic                            RSTN,
	// ahb-lite slave
	input  wire logic                            HSEL,
	input  wire logic [31:0]                     HADDR,
	input  wire logic [1:0]                      HTRANS,
	input  wire logic                            HWRITE,
	input  wire logic [2:0]                      HSIZE,
	input  wire logic [31:0]                     HWDATA,
	input  wire logic                            HREADY,
	output logic      [31:0]                     HRDATA,
	output logic                                 HREADYOUT,
	output logic                                 HRESP,
	// oscillator control and slow oscillator pin
	input  wire logic                            SLOW_OSC_IN,
	output logic                                 FAST_OSC_EN,
	output logic                                 SLOW_OSC_EN,
	// wake-up sources
	input  wire logic                            KEY_CHANGE,
	input  wire logic                            EXT_IRQ,
	input  wire logic                            TIMER_IRQ,
	input  wire logic                            TICK_INTERRUPTS,
	// peripheral gating
	input  wire logic [cmc_pkg::PERIPH_N-1:0]    PERIPH_EN,
	output logic      [cmc_pkg::PERIPH_N-1:0]    PERIPH_RUN,
	// derived clock enables
	output logic                                 FAST_TICK,
	output logic                                 CPU_TICK,
	output logic      [cmc_pkg::TB_W-1:0]        TB_TAPS,
	output logic                                 LCD_CLK,
	output logic                                 PUMP_CLK,
	output logic                                 WDT_CLK,
	// status
	output logic      [2:0]                      MODE,
	output logic                                 CPU_RUN
);
	import cmc_pkg::*;

	// all-ones mask of the low div bits of the fast divider
	function automatic logic [FDIV_W-1:0] div_mask(input logic [2:0] div);
		logic [FDIV_W-1:0] m;
		m = '0;
		for (int i = 0; i < FDIV_W; i++) begin
			if (i < int'(div))
				m[i] = 1'b1;
		end
		return m;
	endfunction

	// register index decode for an ahb address
	function automatic logic [7:0] reg_index(input logic [31:0] a);
		return a[ADDR_MSB:ADDR_LSB];
	endfunction

	// mode-control register fields
	logic              clk_sel;     // 1 fast, 0 slow
	logic [2:0]        div_sel;     // requested divider code
	logic [2:0]        div_act;     // divider code in use
	logic              tb_en;       // time base enable

	// operating mode and settle counter
	cmc_mode_e         mode;
	cmc_mode_e         next_mode;
	logic [WARM_W-1:0] warm_cnt;    // fast cycles spent settling

	// bus data phase
	logic              dp_valid;    // data phase pending
	logic              dp_write;    // pending is a write
	logic [7:0]        dp_idx;      // register index of pending
	logic              rd_done;     // read data already loaded

	// input synchronisers, three stages each
	logic [SY_N-1:0]   sync1;
	logic [SY_N-1:0]   sync2;
	logic [SY_N-1:0]   sync3;
	logic [SY_N-1:0]   filt;        // accepted input levels
	logic              slow_prev;   // last accepted slow level

	// dividers
	logic [FDIV_W-1:0] fast_cnt;
	logic [TB_W-1:0]   tb_cnt;

	// decoded bus activity
	wire               addr_take  = HSEL && HREADY && HTRANS[HTRANS_ACT_BIT];
	wire               wr_ctl     = dp_valid && dp_write && (dp_idx == IDX_MODE_CTRL);
	wire               wr_sleep   = dp_valid && dp_write && (dp_idx == IDX_SLEEP_ENTRY);
	wire               sleep_key  = wr_sleep && (HWDATA[7:0] == SLEEP_KEY);
	wire               rd_wait    = dp_valid && !dp_write && !rd_done;

	// decoded mode groups
	wire               in_normal  = (mode == MODE_NORMAL);
	wire               in_slow    = (mode == MODE_SLOW);
	wire               in_standby = (mode == MODE_STANDBY);
	wire               in_halt    = (mode == MODE_HALT);
	wire               in_warm    = (mode == MODE_WARMUP);

	// fast oscillator only alive in normal and while settling
	wire               fast_on    = in_normal || in_warm;

	wire               tb_run     = in_slow || in_standby || (fast_on && tb_en);

	wire [FDIV_W-1:0]  fast_mask  = div_mask(div_act);
	wire               fast_tick  = fast_on && (fast_cnt == fast_mask);

	// one slow oscillator period seen as a rising accepted level
	wire               slow_tick  = filt[SY_SLOW] && !slow_prev;

	wire               wake_std   = filt[SY_KEY] || filt[SY_EXT] || filt[SY_TMR] || filt[SY_TICK];
	wire               wake_halt  = filt[SY_KEY] || filt[SY_EXT];

	wire               warm_done  = (warm_cnt == WARM_W'(STABLE_CYCLES - 1));

	wire [31:0]        ctl_rd     = {24'h000000, clk_sel, div_sel, tb_en, 1'b1, 2'b00};
	wire [31:0]        rd_value   = (dp_idx == IDX_MODE_CTRL) ? ctl_rd : 32'h00000000;

	// bus answers: writes zero-wait, reads one wait state
	assign HREADYOUT = !rd_wait;
	assign HRESP     = 1'b0;

	// status decode straight from the mode register, slow enable also from tb_en
	assign MODE        = mode;
	assign FAST_OSC_EN = fast_on;
	assign SLOW_OSC_EN = tb_run;
	assign CPU_RUN     = in_normal || in_slow;

	assign TB_TAPS  = tb_cnt;
	assign LCD_CLK  = tb_cnt[TAP_LCD];
	assign PUMP_CLK = tb_cnt[TAP_PUMP];
	assign WDT_CLK  = tb_cnt[TAP_WDT];

	// three-stage synchronisers; stage one feeds stage two only
	generate
		for (genvar g = 0; g < SY_N; g++) begin : g_sync
			wire raw = (g == SY_KEY)  ? KEY_CHANGE :
			           (g == SY_EXT)  ? EXT_IRQ :
			           (g == SY_TMR)  ? TIMER_IRQ :
			           (g == SY_TICK) ? TICK_INTERRUPTS : SLOW_OSC_IN;

			// level accepted only once stages two and three agree
			always_ff @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
					sync3[g] <= 1'b0;
					filt[g]  <= 1'b0;
				end else begin
					sync1[g] <= raw;
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					if (sync2[g] == sync3[g])
						filt[g] <= sync3[g];
				end
			end
		end
	endgenerate

	// slow edge detector history
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			slow_prev <= 1'b0;
		else
			slow_prev <= filt[SY_SLOW];
	end

	// ahb address phase capture and read data load
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_idx   <= 8'h00;
			rd_done  <= 1'b0;
			HRDATA   <= 32'h00000000;
		end else if (rd_wait) begin
			// sampled a cycle late so a write just before is seen
			rd_done <= 1'b1;
			HRDATA  <= rd_value;
		end else if (HREADY) begin
			dp_valid <= addr_take;
			dp_write <= HWRITE;
			// upper address bits must be zero, else unmapped
			dp_idx   <= (HADDR[31:ADDR_MSB+1] == '0 && HADDR[ADDR_LSB-1:0] == '0) ?
			            reg_index(HADDR) : 8'hFF;
			rd_done  <= 1'b0;
		end
	end

	// mode-control register; bit 2 is a strobe, never stored
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			clk_sel <= CLKSEL_RST;
			div_sel <= DIV_RST;
			tb_en   <= TB_EN_RST;
		end else if (wr_ctl) begin
			clk_sel <= HWDATA[CLKSEL_BIT];
			div_sel <= HWDATA[DIV_MSB:DIV_LSB];
			tb_en   <= HWDATA[TB_EN_BIT];
		end
	end

	// fast divider; restart on every output tick
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fast_cnt <= '0;
			div_act  <= DIV_RST;
		end else if (!fast_on) begin
			fast_cnt <= '0;
		end else if (fast_tick) begin
			fast_cnt <= '0;
			div_act  <= div_sel;
		end else begin
			fast_cnt <= fast_cnt + 1'b1;
		end
	end

	// slow time base ripple divider
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			tb_cnt <= '0;
		else if (wr_ctl && !HWDATA[TB_CLR_BIT])
			tb_cnt <= '0;
		else if (tb_run && slow_tick)
			tb_cnt <= tb_cnt + 1'b1;
	end

	// settle counter runs only while warming up
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			warm_cnt <= '0;
		else if (in_warm)
			warm_cnt <= warm_cnt + 1'b1;
		else
			warm_cnt <= '0;
	end

	// mode sequencing
	always_comb begin
		next_mode = mode;
		case (mode)
			MODE_NORMAL: begin
				if (sleep_key)
					next_mode = tb_en ? MODE_STANDBY : MODE_HALT;
				else if (wr_ctl && !HWDATA[CLKSEL_BIT])
					next_mode = MODE_SLOW;
			end
			MODE_SLOW: begin
				if (sleep_key)
					next_mode = tb_en ? MODE_STANDBY : MODE_HALT;
				else if (wr_ctl && HWDATA[CLKSEL_BIT])
					next_mode = MODE_WARMUP;
			end
			MODE_WARMUP: begin
				// software may change its mind while settling
				if (wr_ctl && !HWDATA[CLKSEL_BIT])
					next_mode = MODE_SLOW;
				else if (warm_done)
					next_mode = MODE_NORMAL;
			end
			MODE_STANDBY: begin
				if (wake_std)
					next_mode = clk_sel ? MODE_WARMUP : MODE_SLOW;
			end
			MODE_HALT: begin
				if (wake_halt)
					next_mode = clk_sel ? MODE_WARMUP : MODE_SLOW;
			end
			default: begin
				// unused codes fall back to a running mode
				next_mode = MODE_NORMAL;
			end
		endcase
	end

	// mode register
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			mode <= MODE_NORMAL;
		else
			mode <= next_mode;
	end

	// registered clock enables; a pulse form cannot make a runt
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			FAST_TICK <= 1'b0;
			CPU_TICK  <= 1'b0;
		end else begin
			FAST_TICK <= fast_tick;
			CPU_TICK  <= in_normal ? fast_tick : (in_slow ? slow_tick : 1'b0);
		end
	end

	// peripheral gating; halt turns every peripheral off
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			PERIPH_RUN <= '0;
		else
			PERIPH_RUN <= in_halt ? '0 : PERIPH_EN;
	end

endmodule

// File: logic/cmc_pkg.sv
package cmc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_SLEEP_ENTRY = 8'h15;
	localparam logic [7:0]  IDX_MODE_CTRL   = 8'h17;
	localparam int unsigned ADDR_LSB        = 2;
	localparam int unsigned ADDR_MSB        = 9;

	// mode-control field positions
	localparam int unsigned CLKSEL_BIT = 7;
	localparam int unsigned DIV_MSB    = 6;
	localparam int unsigned DIV_LSB    = 4;
	localparam int unsigned TB_EN_BIT  = 3;
	localparam int unsigned TB_CLR_BIT = 2;

	// reset values of the mode-control fields
	localparam logic [2:0] DIV_RST    = 3'h0;
	localparam logic       TB_EN_RST  = 1'b1;
	localparam logic       CLKSEL_RST = 1'b1;

	// sleep-entry key
	localparam logic [7:0] SLEEP_KEY = 8'h5A;

	// fast oscillator settle time, in fast oscillator cycles
	localparam int unsigned STABLE_CYCLES = 512;
	localparam int unsigned WARM_W        = 10;

	// fast divider and slow time base widths
	localparam int unsigned FDIV_W = 7;
	localparam int unsigned TB_W   = 14;

	// time base taps handed to consumers (tap n = 16KHz / 2^n)
	localparam int unsigned TAP_PUMP = 3;
	localparam int unsigned TAP_LCD  = 8;
	localparam int unsigned TAP_WDT  = 13;

	// positions in the synchronised input vector
	localparam int unsigned SY_KEY  = 0;
	localparam int unsigned SY_EXT  = 1;
	localparam int unsigned SY_TMR  = 2;
	localparam int unsigned SY_TICK = 3;
	localparam int unsigned SY_SLOW = 4;
	localparam int unsigned SY_N    = 5;

	// number of peripheral enables
	localparam int unsigned PERIPH_N = 4;

	// ahb transfer type bit that marks an active transfer
	localparam int unsigned HTRANS_ACT_BIT = 1;

	// operating modes
	typedef enum logic [2:0] {
		MODE_NORMAL  = 3'b000,
		MODE_SLOW    = 3'b001,
		MODE_STANDBY = 3'b010,
		MODE_HALT    = 3'b011,
		MODE_WARMUP  = 3'b100
	} cmc_mode_e;

endpackage

// File: bench/cmc_assertions.sv
`timescale 1ns/1ps
module cmc_checker
	import cmc_pkg::*;
(
	// clock and reset
	input wire logic                CLK,
	input wire logic                RSTN,
	// register bus
	input wire logic                HSEL,
	input wire logic [31:0]         HADDR,
	input wire logic [1:0]          HTRANS,
	input wire logic                HWRITE,
	input wire logic [31:0]         HWDATA,
	input wire logic                HREADY,
	input wire logic [31:0]         HRDATA,
	input wire logic                HREADYOUT,
	// clocks and status
	input wire logic                FAST_OSC_EN,
	input wire logic                SLOW_OSC_EN,
	input wire logic [PERIPH_N-1:0] PERIPH_RUN,
	input wire logic                FAST_TICK,
	input wire logic                CPU_TICK,
	input wire logic [TB_W-1:0]     TB_TAPS,
	input wire logic                LCD_CLK,
	input wire logic                PUMP_CLK,
	input wire logic                WDT_CLK,
	input wire logic [2:0]          MODE,
	input wire logic                CPU_RUN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// address phase decode
	wire        taken     = HSEL && HREADY && HTRANS[HTRANS_ACT_BIT];
	wire        ctl_sel   = HADDR[ADDR_MSB:ADDR_LSB] == IDX_MODE_CTRL;
	wire        sleep_sel = HADDR[ADDR_MSB:ADDR_LSB] == IDX_SLEEP_ENTRY;
	logic       wr_ctl;   // write data phase, mode register
	logic       wr_sleep; // write data phase, sleep register
	logic [10:0] warm_cnt; // cycles spent settling the fast oscillator
	// data phase trackers and warm-up length counter
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_ctl   <= 1'h0;
			wr_sleep <= 1'h0;
			warm_cnt <= 11'h0;
		end else begin
			wr_ctl   <= taken && HWRITE && ctl_sel;
			wr_sleep <= taken && HWRITE && sleep_sel;
			warm_cnt <= (MODE == MODE_WARMUP) ? warm_cnt + 11'h1 : 11'h0;
		end
	end
	a_reset_normal: assert property (!$past(RSTN) |-> MODE == MODE_NORMAL && CPU_RUN)
		else $error("mode after reset is not normal");
	a_fast_osc_mode: assert property (FAST_OSC_EN == (MODE == MODE_NORMAL || MODE == MODE_WARMUP))
		else $error("fast oscillator enable disagrees with mode");
	a_cpu_run_mode: assert property (CPU_RUN == (MODE == MODE_NORMAL || MODE == MODE_SLOW))
		else $error("cpu run disagrees with mode");
	a_standby_slow: assert property (MODE == MODE_STANDBY && $past(MODE) == MODE_STANDBY
		|-> SLOW_OSC_EN && !CPU_TICK)
		else $error("standby lost slow clock or ticks cpu");
	a_halt_all_off: assert property (MODE == MODE_HALT && $past(MODE) == MODE_HALT
		|-> !SLOW_OSC_EN && PERIPH_RUN == '0 && $stable(TB_TAPS))
		else $error("halt left something running");
	a_slow_entry: assert property (wr_ctl && !HWDATA[CLKSEL_BIT] && MODE == MODE_NORMAL |=> MODE == MODE_SLOW)
		else $error("clock select clear did not enter slow");
	a_tb_clear: assert property (wr_ctl && !HWDATA[TB_CLR_BIT] |=> TB_TAPS == '0)
		else $error("time base not cleared");
	a_sleep_entry: assert property (wr_sleep && HWDATA[7:0] == SLEEP_KEY && CPU_RUN
		|=> MODE == MODE_STANDBY || MODE == MODE_HALT)
		else $error("sleep key did not stop cpu");
	a_bit2_read: assert property (taken && !HWRITE && ctl_sel |=> !HREADYOUT ##1 HREADYOUT && HRDATA[TB_CLR_BIT])
		else $error("mode register read wait or bit 2 wrong");
	a_warmup_len: assert property (MODE == MODE_NORMAL && $past(MODE) == MODE_WARMUP
		|-> warm_cnt >= 11'h1FF && warm_cnt <= 11'h201)
		else $error("fast oscillator settle time wrong");
	a_taps_route: assert property (LCD_CLK == TB_TAPS[TAP_LCD] && PUMP_CLK == TB_TAPS[TAP_PUMP]
		&& WDT_CLK == TB_TAPS[TAP_WDT])
		else $error("time base tap routing wrong");
	a_cpu_fast_src: assert property (MODE == MODE_NORMAL && $past(MODE) == MODE_NORMAL
		|-> CPU_TICK == FAST_TICK)
		else $error("cpu tick not taken from fast divider in normal");
	a_slow_no_fast: assert property (MODE == MODE_SLOW && $past(MODE) == MODE_SLOW |-> !FAST_TICK)
		else $error("fast divider ticks in slow mode");
endmodule
bind cmc_clock_mode_control cmc_checker i_chk (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .FAST_OSC_EN(FAST_OSC_EN), .SLOW_OSC_EN(SLOW_OSC_EN), .PERIPH_RUN(PERIPH_RUN),
	.FAST_TICK(FAST_TICK), .CPU_TICK(CPU_TICK), .TB_TAPS(TB_TAPS), .LCD_CLK(LCD_CLK), .PUMP_CLK(PUMP_CLK),
	.WDT_CLK(WDT_CLK), .MODE(MODE), .CPU_RUN(CPU_RUN));

// File: bench/clock_mode_control_bench.sv
`timescale 1ns/1ps
module clock_mode_control_bench;
	import cmc_pkg::*;
	logic        CLK = 1'h0, RSTN = 1'h0, HSEL = 1'h0, HWRITE = 1'h0, SLOW_OSC_IN = 1'h0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rdv;
	logic [1:0]  HTRANS = 2'h0;
	logic [2:0]  HSIZE = 3'h2, MODE;
	logic [3:0]  wake = 4'h0, PERIPH_EN = 4'h0, PERIPH_RUN;
	logic [13:0] TB_TAPS;
	logic        HREADYOUT, HRESP, FAST_OSC_EN, SLOW_OSC_EN, FAST_TICK, CPU_RUN;
	int          n_mismatch = 0, n_tests = 0, cyc = 0, gap;
	wire         HREADY = HREADYOUT; // single slave drives ready
	cmc_clock_mode_control i_dut (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .SLOW_OSC_IN(SLOW_OSC_IN), .FAST_OSC_EN(FAST_OSC_EN),
		.SLOW_OSC_EN(SLOW_OSC_EN), .KEY_CHANGE(wake[0]), .EXT_IRQ(wake[1]), .TIMER_IRQ(wake[2]),
		.TICK_INTERRUPTS(wake[3]), .PERIPH_EN(PERIPH_EN), .PERIPH_RUN(PERIPH_RUN), .FAST_TICK(FAST_TICK),
		.CPU_TICK(), .TB_TAPS(TB_TAPS), .LCD_CLK(), .PUMP_CLK(), .WDT_CLK(), .MODE(MODE), .CPU_RUN(CPU_RUN));
	always #50 CLK = ~CLK;
	// hang guard, well above the expected run length
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task results;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one single transfer; ready is judged just before the edge that samples it
	task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		HSEL <= 1'h1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {22'h0, idx, 2'h0};
		do @(negedge CLK); while (HREADY !== 1'h1);
		@(posedge CLK);
		HSEL <= 1'h0;
		HTRANS <= 2'h0;
		HWDATA <= {24'h0, wd};
		do @(negedge CLK); while (HREADY !== 1'h1);
		rdv = HRDATA;
		@(posedge CLK);
	endtask
	task rd(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'h0, idx, 8'h0);
		chk("read data", rdv, {24'h0, exp});
		chk("response", {31'h0, HRESP}, 32'h0);
	endtask
	// bounded wait for a mode, then compare it
	task wait_mode(input logic [2:0] m, input int lim);
		for (int i = 0; i < lim && MODE !== m; i++) @(negedge CLK);
		chk("mode", MODE, m);
		@(posedge CLK);
	endtask
	// slow oscillator pulses, idle low between bursts
	task slow(input int n);
		repeat (n) begin
			SLOW_OSC_IN <= 1'h1;
			repeat (4) @(posedge CLK);
			SLOW_OSC_IN <= 1'h0;
			repeat (4) @(posedge CLK);
		end
		repeat (6) @(posedge CLK);
	endtask
	task tick_gap;
		gap = 0;
		do begin
			@(negedge CLK);
			gap++;
		end while (FAST_TICK !== 1'h1 && gap < 300);
	endtask
	initial begin
		repeat (20) @(posedge CLK);
		RSTN <= 1'h1;
		@(posedge CLK);
		rd(IDX_MODE_CTRL, 8'h8C);
		chk("reset mode", MODE, MODE_NORMAL);
		bus(1'h1, 8'h20, 8'hFF);
		rd(8'h20, 8'h00);
		PERIPH_EN <= 4'hA;
		repeat (3) @(posedge CLK);
		chk("periph run", PERIPH_RUN, 4'hA);
		// every divider code, period measured tick to tick
		// even code 7 stays far above 16KHz at this clock
		for (int d = 0; d < 8; d++) begin
			bus(1'h1, IDX_MODE_CTRL, {1'h1, 3'(d), 4'hC});
			rd(IDX_MODE_CTRL, {1'h1, 3'(d), 4'hC});
			tick_gap();
			tick_gap();
			tick_gap();
			chk("fast period", gap, 1 << d);
			@(posedge CLK);
		end
		// count first, so that the clear has something to undo
		slow(20);
		chk("base count", TB_TAPS, 14'h14);
		bus(1'h1, IDX_MODE_CTRL, 8'h88);
		repeat (6) @(posedge CLK);
		chk("cleared base", TB_TAPS, 14'h0);
		rd(IDX_MODE_CTRL, 8'h8C);
		bus(1'h1, IDX_MODE_CTRL, 8'h84);
		slow(5);
		chk("base stopped", TB_TAPS, 14'h0);
		chk("slow osc off", SLOW_OSC_EN, 1'h0);
		bus(1'h1, IDX_MODE_CTRL, 8'h0C);
		wait_mode(MODE_SLOW, 4);
		chk("fast osc in slow", FAST_OSC_EN, 1'h0);
		slow(3);
		chk("base in slow", TB_TAPS, 14'h3);
		bus(1'h1, IDX_SLEEP_ENTRY, 8'h5B);
		// look after the data edge, where a wrong mode would show
		@(negedge CLK);
		chk("wrong key", MODE, MODE_SLOW);
		// standby wakes on each of the four sources
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, IDX_SLEEP_ENTRY, SLEEP_KEY);
			wait_mode(MODE_STANDBY, 2);
			wake <= 4'h1 << i;
			wait_mode(MODE_SLOW, 12);
			wake <= 4'h0;
			repeat (8) @(posedge CLK);
		end
		// halt ignores the timer and tick sources
		bus(1'h1, IDX_MODE_CTRL, 8'h04);
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, IDX_SLEEP_ENTRY, SLEEP_KEY);
			wait_mode(MODE_HALT, 2);
			repeat (2) @(posedge CLK);
			chk("periph in halt", PERIPH_RUN, 4'h0);
			wake <= 4'h1 << i;
			if (i > 1) begin
				repeat (12) @(posedge CLK);
				chk("halt holds", MODE, MODE_HALT);
				wake <= 4'h1;
			end
			wait_mode(MODE_SLOW, 12);
			wake <= 4'h0;
			repeat (8) @(posedge CLK);
		end
		bus(1'h1, IDX_MODE_CTRL, 8'h8C);
		wait_mode(MODE_WARMUP, 4);
		repeat (500) @(negedge CLK);
		chk("still settling", MODE, MODE_WARMUP);
		wait_mode(MODE_NORMAL, 20);
		bus(1'h1, IDX_SLEEP_ENTRY, SLEEP_KEY);
		wait_mode(MODE_STANDBY, 2);
		wake <= 4'h8;
		wait_mode(MODE_WARMUP, 12);
		wake <= 4'h0;
		wait_mode(MODE_NORMAL, 600);
		results();
	end
endmodule
